//--- rtl/float_accel_control_status.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/10ps
`include "fpu_params.svh"

// Contract
// - Writing start launches run, hardware clears it
// - Function codes 0-6, 25, 26 selected
// - Codes 16-20 are vector operations
// - Codes 21-24 mac, div, root, compare
// - Bits 7:6 set refinement pass count
// - Bits 11:8 give vector length n
// - Status bit 0 shows completion
// - Status bit 1 busy during run
// - Status bits 3:2 hold compare outcome
// - Status bit 4 flags zero result
// - Status bit 5 flags infinite result
// - Status bit 6 flags invalid input
// - Status bit 7 flags underflow
// - Status bit 8 flags overflow
// - Status bit 9 flags rounded_flag result
// - Status bit 10 flags integer overflow
// - Status bit 11 flags division by zero
// - Mask bits gate done and invalid interrupts
module float_accel_control_status (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // Datapath launch
  output logic                      dp_start,
  output fpu_pkg::run_cfg_t         dp_cfg,
  // Datapath completion
  input  wire logic                 dp_done,
  input  fpu_pkg::calc_flags_t      dp_flags,
  // Interrupt lines
  output logic                      done_irq,
  output logic                      invalid_irq
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------

  // Implemented codes only; the gaps are reserved
  function automatic logic func_ok(input logic [4:0] f);
    logic ok;
    ok = 1'b0;
    case (f)
      fpu_pkg::FN_ASIN,
      fpu_pkg::FN_ACOS,
      fpu_pkg::FN_ATAN,
      fpu_pkg::FN_ATAN2,
      fpu_pkg::FN_SIN,
      fpu_pkg::FN_COS,
      fpu_pkg::FN_TAN:   ok = 1'b1;
      fpu_pkg::FN_VSUM,
      fpu_pkg::FN_SQSUM,
      fpu_pkg::FN_VSUB,
      fpu_pkg::FN_PROD,
      fpu_pkg::FN_DOT:   ok = 1'b1;
      fpu_pkg::FN_MAC,
      fpu_pkg::FN_DIV,
      fpu_pkg::FN_RROOT,
      fpu_pkg::FN_CMP:   ok = 1'b1;
      fpu_pkg::FN_I2F,
      fpu_pkg::FN_F2I:   ok = 1'b1;
      default:           ok = 1'b0;
    endcase
    return ok;
  endfunction : func_ok

  // Operations that consume the vector length
  function automatic logic uses_len(input logic [4:0] f);
    logic v;
    v = 1'b0;
    case (f)
      fpu_pkg::FN_VSUM,
      fpu_pkg::FN_SQSUM,
      fpu_pkg::FN_VSUB,
      fpu_pkg::FN_PROD,
      fpu_pkg::FN_DOT:   v = 1'b1;
      default:           v = 1'b0;
    endcase
    return v;
  endfunction : uses_len

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  // Async assert, synchronous release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire logic rst_int_n;
  assign rst_int_n = rst_sync_q;

  // ----------------------------------------
  // Bus address phase
  // ----------------------------------------
  wire logic bus_take;
  wire logic wr_take;
  wire logic rd_take;

  // Only whole-word writes are committed
  assign bus_take = hsel & htrans[1] & hready;
  assign wr_take  = bus_take & hwrite & (hsize == `HSIZE_WORD);
  assign rd_take  = bus_take & ~hwrite;

  logic       wr_pend_q;
  logic [4:0] wr_addr_q;
  logic       rd_pend_q;
  logic [4:0] rd_addr_q;

  // Capture address phase for the data phase
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 5'h00;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 5'h00;
    end
    else
    begin
      wr_pend_q <= wr_take;
      wr_addr_q <= wr_take ? haddr[4:0] : wr_addr_q;
      rd_pend_q <= rd_take;
      rd_addr_q <= rd_take ? haddr[4:0] : rd_addr_q;
    end
  end

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  wire logic ctrl_wr;
  wire logic stat_wr;
  wire logic mask_wr;

  // Upper address bits are not decoded
  assign ctrl_wr = wr_pend_q & (wr_addr_q == `OFS_CTRL);
  assign stat_wr = wr_pend_q & (wr_addr_q == `OFS_STAT);
  assign mask_wr = wr_pend_q & (wr_addr_q == `OFS_MASK);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic       start_q;
  logic [4:0] func_q;
  logic [1:0] passes_q;
  logic [3:0] len_q;

  wire logic  start_set;
  wire logic  start_clr;
  wire logic  start_d;
  wire logic  seq_launch;
  wire logic  seq_busy;

  // Writing 0 leaves a pending start alone
  assign start_set = ctrl_wr & hwdata[`CTRL_START];

  // Cleared once launched, or dropped for a reserved code
  assign start_clr = seq_launch | (start_q & ~func_ok(func_q));

  // A fresh write beats the clear in the same cycle
  assign start_d = start_set | (start_q & ~start_clr);

  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      start_q  <= `START_RST;
      func_q   <= 5'h00;
      passes_q <= 2'h0;
      len_q    <= 4'h0;
    end
    else
    begin
      start_q  <= start_d;
      func_q   <= ctrl_wr ? hwdata[`CTRL_FUNC_HI:`CTRL_FUNC_LO] : func_q;
      passes_q <= ctrl_wr ? hwdata[`CTRL_PASS_HI:`CTRL_PASS_LO] : passes_q;
      len_q    <= ctrl_wr ? hwdata[`CTRL_LEN_HI:`CTRL_LEN_LO] : len_q;
    end
  end

  // ----------------------------------------
  // Launch to the datapath
  // ----------------------------------------
  wire logic              go;
  wire logic              launch_now;
  fpu_pkg::run_cfg_t      cfg_d;
  fpu_pkg::run_cfg_t      cfg_q;

  // Reserved codes never reach the sequencer
  assign go         = start_q & func_ok(func_q);
  assign launch_now = go & ~seq_busy;

  // Settings frozen at launch so rewrites mid-run are harmless
  assign cfg_d.func   = fpu_pkg::func_t'(func_q);
  assign cfg_d.passes = passes_q;
  assign cfg_d.len    = uses_len(func_q) ? len_q : 4'h0;

  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      cfg_q <= '0;
    else
      cfg_q <= launch_now ? cfg_d : cfg_q;
  end

  assign dp_cfg = cfg_q;

  // ----------------------------------------
  // Run sequencing
  // ----------------------------------------
  wire logic              seq_fin;
  fpu_pkg::calc_flags_t   seq_flags;

  run_sequencer u_seq (
    .clk      (clk),
    .rst_n    (rst_int_n),
    .go       (go),
    .dp_done  (dp_done),
    .dp_flags (dp_flags),
    .launch_o (seq_launch),
    .busy_o   (seq_busy),
    .fin_o    (seq_fin),
    .flags_o  (seq_flags)
  );

  // Sequencer launch flop drives the pin directly
  assign dp_start = seq_launch;

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  logic        done_q;
  logic [9:0]  flags_q;
  wire logic   done_d;
  wire logic [9:0] flags_d;

  // Completion wins over launch and over software writes
  assign done_d = seq_fin ? 1'b1 :
                  seq_launch ? 1'b0 :
                  stat_wr ? hwdata[`STAT_DONE] : done_q;

  // Outcome lands all at once; busy bit is hardware only
  assign flags_d = seq_fin ? seq_flags :
                   seq_launch ? `FLAGS_RST :
                   stat_wr ? hwdata[`STAT_FLAG_HI:`STAT_FLAG_LO] :
                   flags_q;

  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      done_q  <= 1'b0;
      flags_q <= `FLAGS_RST;
    end
    else
    begin
      done_q  <= done_d;
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------
  // Interrupt mask and request lines
  // ----------------------------------------
  logic [1:0] mask_q;

  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
      mask_q <= `MASK_RST;
    else
      mask_q <= mask_wr ? hwdata[1:0] : mask_q;
  end

  // A set mask bit blocks its line, cleared means enabled
  wire logic done_irq_d;
  wire logic inv_irq_d;

  assign done_irq_d = done_q & ~mask_q[`MASK_DONE];
  assign inv_irq_d  = flags_q[6 - `STAT_FLAG_LO] & ~mask_q[`MASK_INVALID];

  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      done_irq    <= 1'b0;
      invalid_irq <= 1'b0;
    end
    else
    begin
      done_irq    <= done_irq_d;
      invalid_irq <= inv_irq_d;
    end
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  wire logic [31:0] ctrl_rd;
  wire logic [31:0] stat_rd;
  wire logic [31:0] mask_rd;
  wire logic [31:0] rd_mux;

  // Reserved bits read zero
  assign ctrl_rd = {20'h00000, len_q, passes_q, func_q, start_q};
  assign stat_rd = {20'h00000, flags_q, seq_busy, done_q};
  assign mask_rd = {30'h00000000, mask_q};

  // Unmapped words, operand slots included, read zero
  assign rd_mux = (rd_addr_q == `OFS_CTRL) ? ctrl_rd :
                  (rd_addr_q == `OFS_STAT) ? stat_rd :
                  (rd_addr_q == `OFS_MASK) ? mask_rd :
                  32'h00000000;

  // ----------------------------------------
  // Bus response
  // ----------------------------------------

  // Reads take one wait state so a write just before is seen
  always_ff @(posedge clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end
    else
    begin
      hreadyout <= ~rd_take;
      hresp     <= 1'b0;                                  // Always OKAY
      hrdata    <= rd_pend_q ? rd_mux : hrdata;
    end
  end

endmodule : float_accel_control_status

//--- rtl/fpu_params.svh
`ifndef FPU_PARAMS_SVH
`define FPU_PARAMS_SVH

// ----------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------
`define OFS_CTRL      5'h00
`define OFS_STAT      5'h04
`define OFS_MASK      5'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_START    0
`define CTRL_FUNC_LO  1
`define CTRL_FUNC_HI  5
`define CTRL_PASS_LO  6
`define CTRL_PASS_HI  7
`define CTRL_LEN_LO   8
`define CTRL_LEN_HI   11

// ----------------------------------------
// Status and mask register fields
// ----------------------------------------
`define STAT_DONE     0
`define STAT_BUSY     1
`define STAT_FLAG_LO  2
`define STAT_FLAG_HI  11
`define MASK_DONE     0
`define MASK_INVALID  1

// ----------------------------------------
// Reset values and bus constants
// ----------------------------------------
`define CTRL_RST      12'h000
`define START_RST     1'b0
`define FLAGS_RST     10'h000
`define MASK_RST      2'h0
`define HSIZE_WORD    3'h2

`endif

//--- rtl/fpu_pkg.sv
package fpu_pkg;

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  typedef enum logic [4:0] {
    FN_ASIN   = 5'h00,
    FN_ACOS   = 5'h01,
    FN_ATAN   = 5'h02,
    FN_ATAN2  = 5'h03,
    FN_SIN    = 5'h04,
    FN_COS    = 5'h05,
    FN_TAN    = 5'h06,
    FN_VSUM   = 5'h10,
    FN_SQSUM  = 5'h11,
    FN_VSUB   = 5'h12,
    FN_PROD   = 5'h13,
    FN_DOT    = 5'h14,
    FN_MAC    = 5'h15,
    FN_DIV    = 5'h16,
    FN_RROOT  = 5'h17,
    FN_CMP    = 5'h18,
    FN_I2F    = 5'h19,
    FN_F2I    = 5'h1A
  } func_t;

  // ----------------------------------------
  // Run sequencer states
  // ----------------------------------------
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_t;

  // Launch settings handed to the datapath
  typedef struct packed {
    func_t       func;
    logic [1:0]  passes;
    logic [3:0]  len;
  } run_cfg_t;

  // Outcome flags, laid out as status bits 11:2
  typedef struct packed {
    logic        zero_div;
    logic        int_ovf;
    logic        rounded;
    logic        overflow;
    logic        underflow;
    logic        invalid;
    logic        unbounded;
    logic        zero;
    logic [1:0]  cmp;
  } calc_flags_t;

endpackage : fpu_pkg

//--- rtl/run_sequencer.sv
`timescale 1ns/10ps

module run_sequencer (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Start request
  input  wire logic                 go,
  // Datapath completion
  input  wire logic                 dp_done,
  input  fpu_pkg::calc_flags_t      dp_flags,
  // Run state
  output logic                      launch_o,
  output logic                      busy_o,
  output logic                      fin_o,
  output fpu_pkg::calc_flags_t      flags_o
);

  // ----------------------------------------
  // Next-state decode
  // ----------------------------------------
  fpu_pkg::seq_state_t state_q;
  fpu_pkg::seq_state_t state_d;
  wire logic           begin_run;
  wire logic           end_run;

  // A done seen while idle is stray and ignored
  assign begin_run = (state_q == fpu_pkg::SEQ_IDLE) && go;
  assign end_run   = (state_q == fpu_pkg::SEQ_RUN) && dp_done;

  always_comb
  begin
    case (state_q)
      fpu_pkg::SEQ_IDLE: state_d = go ? fpu_pkg::SEQ_RUN : fpu_pkg::SEQ_IDLE;
      fpu_pkg::SEQ_RUN:  state_d = dp_done ? fpu_pkg::SEQ_IDLE : fpu_pkg::SEQ_RUN;
      default:           state_d = fpu_pkg::SEQ_IDLE;
    endcase
  end

  // ----------------------------------------
  // State and outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= fpu_pkg::SEQ_IDLE;
      launch_o <= 1'b0;
      busy_o   <= 1'b0;
      fin_o    <= 1'b0;
      flags_o  <= '0;
    end
    else
    begin
      state_q  <= state_d;
      launch_o <= begin_run;
      busy_o   <= begin_run | (busy_o & ~end_run);
      fin_o    <= end_run;
      flags_o  <= end_run ? dp_flags : flags_o;
    end
  end

endmodule : run_sequencer

//--- testbench/ctl_status_assertions.sv
`timescale 1ns/10ps

// ----------------------------------------
// Port checker for the control/status block
// ----------------------------------------
module ctl_status_checker (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_n,
  // Bus side
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [2:0]           hsize,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [31:0]          hrdata,
  // Datapath side
  input wire logic                 dp_start,
  input wire fpu_pkg::run_cfg_t    dp_cfg,
  input wire logic                 dp_done,
  input wire fpu_pkg::calc_flags_t dp_flags,
  // Interrupt lines
  input wire logic                 done_irq,
  input wire logic                 invalid_irq
);
  logic run_q;
  wire  take_w = hsel && htrans[1] && hready;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Run in flight, seen from the launch and completion pulses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_q <= 1'b0;
    else if (dp_start)
      run_q <= 1'b1;
    else if (dp_done)
      run_q <= 1'b0;
  end

  a_start_pulse: assert property (dp_start |=> !dp_start)
    else $error("launch pulse longer than one cycle");
  a_one_run: assert property (dp_start |-> !run_q)
    else $error("launch while a run is in flight");
  a_cfg_at_launch: assert property ($changed(dp_cfg) |-> dp_start)
    else $error("run settings changed without a launch");
  a_len_scalar: assert property (dp_start && !(dp_cfg.func inside {[5'h10:5'h14]})
    |-> dp_cfg.len == 4'h0)
    else $error("length given to a scalar operation");
  a_code_valid: assert property (dp_start
    |-> dp_cfg.func inside {[5'h00:5'h06], [5'h10:5'h1A]})
    else $error("launch with a reserved code");
  a_launch_clears: assert property (dp_start |-> ##2 !done_irq && !invalid_irq)
    else $error("old flags still raise an interrupt after launch");
  a_read_wait: assert property (take_w && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not exactly one wait cycle");
  a_write_ready: assert property (take_w && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data moved outside a read");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response other than OKAY");

  cover property (dp_start);
  cover property (dp_done && run_q);
  cover property (take_w && !hwrite);
endmodule : ctl_status_checker

//--- testbench/tb_top.sv
`timescale 1ns/10ps

// ----------------------------------------
// Self-checking bench, bus master and datapath stand-in
// ----------------------------------------
module tb_top;
  logic                 clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0]          haddr, hwdata, hrdata, rd, st_keep;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic                 dp_start, dp_done, done_irq, invalid_irq;
  fpu_pkg::run_cfg_t    dp_cfg;
  fpu_pkg::calc_flags_t dp_flags;
  int                   bad_count, compares;

  // Slave ready feeds straight back as the bus ready
  float_accel_control_status dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dp_start(dp_start),
    .dp_cfg(dp_cfg), .dp_done(dp_done), .dp_flags(dp_flags), .done_irq(done_irq),
    .invalid_irq(invalid_irq));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One single transfer at the current hsize; read data lands in rd
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  task wait_start;
    @(posedge clk);
    while (dp_start !== 1'b1) @(posedge clk);
  endtask : wait_start

  task finish_run(input logic [9:0] f);
    @(posedge clk);
    dp_done  <= 1'b1;
    dp_flags <= f;
    @(posedge clk);
    dp_done  <= 1'b0;
  endtask : finish_run

  task no_start;
    repeat (6)
    begin
      @(posedge clk);
      chk({31'h0, dp_start}, 32'h0);
    end
  endtask : no_start

  task t_regs;
    rchk(32'h0, 32'h0);
    rchk(32'h4, 32'h0);
    rchk(32'h14, 32'h0);
    bus(1'b1, 32'h8, 32'hFFFF_FFFF);
    rchk(32'h18, 32'h0);
    bus(1'b1, 32'h0, 32'hFFFF_FFFE);
    rchk(32'h0, 32'h0000_0FFE);
    // Half-word write must not land, so no start and no new code
    hsize <= 3'h1;
    bus(1'b1, 32'h0, 32'h0000_0021);
    hsize <= 3'h2;
    rchk(32'h0, 32'h0000_0FFE);
  endtask : t_regs

  // Every defined code once, each flag bit and outcome in turn
  task automatic t_codes;
    logic [4:0] cl[18] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h10, 5'h11,
      5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A};
    logic [4:0] c;
    logic [3:0] l, le;
    logic [1:0] p;
    logic [9:0] f;
    for (int i = 0; i < 18; i++)
    begin
      c  = cl[i];
      l  = 4'(i);
      p  = 2'(i);
      le = (c >= 5'h10 && c <= 5'h14) ? l : 4'h0;
      f  = {8'h01 << (i % 8), p};
      bus(1'b1, 32'h0, {20'h0, l, p, c, 1'b1});
      wait_start();
      chk(32'(dp_cfg), {21'h0, c, p, le});
      rchk(32'h4, 32'h2);
      rchk(32'h0, {20'h0, l, p, c, 1'b0});
      finish_run(f);
      rchk(32'h4, {20'h0, f, 2'h1});
      chk({31'h0, done_irq}, 32'h1);
    end
    st_keep = rd;
  endtask : t_codes

  task automatic t_reserved;
    logic [4:0] rl[4] = '{5'h07, 5'h0F, 5'h1B, 5'h1F};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 32'h0, {26'h0, rl[i], 1'b1});
      no_start();
      rchk(32'h4, st_keep);
      rchk(32'h0, {26'h0, rl[i], 1'b0});
    end
  endtask : t_reserved

  // Second start during a run waits for the first to finish
  task t_pending;
    bus(1'b1, 32'h0, {26'h0, 5'h16, 1'b1});
    wait_start();
    bus(1'b1, 32'h0, {26'h0, 5'h18, 1'b1});
    no_start();
    finish_run(10'h200);
    wait_start();
    chk(32'(dp_cfg.func), 32'h18);
    rchk(32'h4, 32'h2);
    finish_run(10'h010);
    rchk(32'h4, 32'h41);
  endtask : t_pending

  task t_mask;
    chk({30'h0, invalid_irq, done_irq}, 32'h3);
    bus(1'b1, 32'h14, 32'h3);
    repeat (2) @(posedge clk);
    chk({30'h0, invalid_irq, done_irq}, 32'h0);
    rchk(32'h14, 32'h3);
    bus(1'b1, 32'h14, 32'h2);
    repeat (2) @(posedge clk);
    chk({30'h0, invalid_irq, done_irq}, 32'h1);
  endtask : t_mask

  // Main sequence
  initial
  begin
    rst_n     = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    dp_done   = 1'b0;
    dp_flags  = '0;
    bad_count = 0;
    compares  = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_codes();
    t_reserved();
    t_pending();
    t_mask();
    results();
  end

  // Hang guard at 20000 cycles, well beyond the few hundred cycles the tests need
  initial
  begin
    #(5 * 20000);
    bad_count++;
    results();
  end
endmodule : tb_top

bind float_accel_control_status ctl_status_checker chk_i (.clk(clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .dp_start(dp_start), .dp_cfg(dp_cfg), .dp_done(dp_done), .dp_flags(dp_flags),
  .done_irq(done_irq), .invalid_irq(invalid_irq));
